/* File: include/ddf_pkg.sv */
package ddf_pkg;
    // ====================================================================
    // Clock and timing
    localparam int CLK_PERIOD_NS     = 4;
    localparam int T_SETUP_NS        = 12;
    localparam int T_WE_PULSE_NS     = 40;
    localparam int T_READ_ACCESS_NS  = 120;
    localparam int T_HOLD_NS         = 20;
    localparam int T_BUSY_SETTLE_NS  = 100;
    localparam int T_RESET_PULSE_NS  = 500;
    localparam int T_RESET_REC_NS    = 200;
    localparam logic [7:0] SETUP_CYC  = 8'((T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] WE_CYC     = 8'((T_WE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] READ_CYC   =
        8'((T_READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] HOLD_CYC   = 8'((T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] SETTLE_CYC =
        8'((T_BUSY_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] RESET_CYC  =
        8'((T_RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] RESREC_CYC =
        8'((T_RESET_REC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // ====================================================================
    // Address map
    localparam int ADDR_W      = 27;
    localparam int DATA_W      = 16;
    localparam int DIE_BIT     = 26;
    localparam int SECTOR_LSB  = 16;
    localparam int SECTOR_COUNT = 2048;
    localparam logic [26:0] DIE0_BASE    = 27'h0000000;
    localparam logic [26:0] DIE1_BASE    = 27'h4000000;
    localparam logic [26:0] UNLOCK1_ADDR = 27'h0000555;
    localparam logic [26:0] UNLOCK2_ADDR = 27'h00002AA;
    localparam logic [26:0] SECTOR_MASK  = 27'h7FF0000;
    localparam logic [9:0]  LAST_DIE_SECTOR = 10'h3FF;

    // ====================================================================
    // Command data
    localparam logic [15:0] UNLOCK1_DATA = 16'h00AA;
    localparam logic [15:0] UNLOCK2_DATA = 16'h0055;
    localparam logic [15:0] ERASE_SETUP  = 16'h0080;
    localparam logic [15:0] SECTOR_ERASE = 16'h0030;
    localparam logic [15:0] PROGRAM_CMD  = 16'h00A0;
    localparam logic [2:0]  ERASE_STEPS  = 3'h6;
    localparam logic [2:0]  PROG_STEPS   = 3'h4;

    typedef enum logic [1:0] {
        OP_READ    = 2'b00,
        OP_PROGRAM = 2'b01,
        OP_ERASE   = 2'b10,
        OP_RESET   = 2'b11
    } ddf_op_e;

    typedef struct packed {
        logic [26:0] addr;
        logic [15:0] data;
    } ddf_step_s;
endpackage

/* File: include/ddf_cyc_if.sv */
`timescale 1ns/100ps
interface ddf_cyc_if;
    logic        req;
    logic        wr;
    logic [26:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic        done;

    modport master (output req, output wr, output addr, output wdata,
                    input rdata, input done);
    modport slave  (input req, input wr, input addr, input wdata,
                    output rdata, output done);
endinterface

/* File: design/ddf_bus_cycle.sv */
`timescale 1ns/100ps
module ddf_bus_cycle
    import ddf_pkg::*;
(
    input  wire logic    mclk,
    input  wire logic    nrst,
    ddf_cyc_if.slave     cyc,
    output logic [26:0]  flashAddr,
    input  wire logic [15:0] flashDqIn,
    output logic [15:0]  flashDqOut,
    output logic         flashDqOe,
    output logic         flashCeN,
    output logic         flashOeN,
    output logic         flashWeN
);
    typedef enum logic [1:0] {
        BC_IDLE   = 2'b00,
        BC_SETUP  = 2'b01,
        BC_STROBE = 2'b10,
        BC_HOLD   = 2'b11
    } ddf_bc_e;

    ddf_bc_e    state;
    logic [7:0] cnt;
    logic       isWrite;

    // ====================================================================
    // Cycle sequencer
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            state <= BC_IDLE;
            cnt   <= 8'h00;
        end else begin
            unique case (state)
                BC_IDLE: begin
                    if (cyc.req) begin
                        state <= BC_SETUP;
                        cnt   <= SETUP_CYC;
                    end
                end
                BC_SETUP: begin
                    if (cnt == 8'h01) begin
                        state <= BC_STROBE;
                        cnt   <= isWrite ? WE_CYC : READ_CYC;
                    end else begin
                        cnt <= cnt - 8'h01;
                    end
                end
                BC_STROBE: begin
                    if (cnt == 8'h01) begin
                        state <= BC_HOLD;
                        cnt   <= HOLD_CYC;
                    end else begin
                        cnt <= cnt - 8'h01;
                    end
                end
                BC_HOLD: begin
                    if (cnt == 8'h01) begin
                        state <= BC_IDLE;
                    end else begin
                        cnt <= cnt - 8'h01;
                    end
                end
            endcase
        end
    end

    // ====================================================================
    // Pin drive, one chip enable shared by both dies
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            isWrite    <= 1'b0;
            flashAddr  <= 27'h0000000;
            flashDqOut <= 16'h0000;
            flashDqOe  <= 1'b0;
            flashCeN   <= 1'b1;
            flashOeN   <= 1'b1;
            flashWeN   <= 1'b1;
        end else begin
            if (state == BC_IDLE && cyc.req) begin
                isWrite    <= cyc.wr;
                flashAddr  <= cyc.addr;
                flashDqOut <= cyc.wdata;
                flashDqOe  <= cyc.wr;
                flashCeN   <= 1'b0;
            end else if (state == BC_HOLD && cnt == 8'h01) begin
                flashCeN  <= 1'b1;
                flashDqOe <= 1'b0;
            end
            flashWeN <= !(isWrite && ((state == BC_SETUP && cnt == 8'h01)
                        || (state == BC_STROBE && cnt != 8'h01)));
            flashOeN <= !(!isWrite && ((state == BC_SETUP && cnt == 8'h01)
                        || (state == BC_STROBE && cnt != 8'h01)));
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            cyc.rdata <= 16'h0000;
            cyc.done  <= 1'b0;
        end else begin
            if (state == BC_STROBE && cnt == 8'h01 && !isWrite) begin
                cyc.rdata <= flashDqIn;
            end
            cyc.done <= (state == BC_HOLD && cnt == 8'h02) ||
                        (state == BC_HOLD && HOLD_CYC == 8'h01);
        end
    end
endmodule // ddf_bus_cycle

/* File: design/ddf_host.sv */
`timescale 1ns/100ps
// Notes on behaviour
// - The host adds the die base address, zero or the second die offset, to command addresses.
// - Sector erase is 555/AA, 2AA/55, 555/80, 555/AA, 2AA/55, then sector address with 30.
// - The host drives the top address bit to the target die during both unlock cycles.
// - The host steers every command address argument to the right die by the top bit.
// - Program and erase completion is taken from the single readyBusyN input, not from one die.
module ddf_host
    import ddf_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        nrst,
    input  wire logic        cmdValid,
    output logic             cmdReady,
    input  wire logic [1:0]  cmdOp,
    input  wire logic [26:0] cmdAddr,
    input  wire logic [15:0] cmdData,
    output logic             rspValid,
    output logic             rspError,
    output logic [15:0]      rspData,
    input  wire logic        protectOuter,
    input  wire logic        accelEnable,
    output logic [26:0]      flashAddr,
    input  wire logic [15:0] flashDqIn,
    output logic [15:0]      flashDqOut,
    output logic             flashDqOe,
    output logic             flashCeN,
    output logic             flashOeN,
    output logic             flashWeN,
    output logic             flashResetN,
    output logic             flashWpN,
    output logic             flashWpElevate,
    output logic             reservedTestInput,
    input  wire logic        readyBusyN
);
    typedef enum logic [2:0] {
        ST_RSTLOW = 3'b000,
        ST_RSTREC = 3'b001,
        ST_IDLE   = 3'b010,
        ST_WRITE  = 3'b011,
        ST_READ   = 3'b100,
        ST_SETTLE = 3'b101,
        ST_BUSY   = 3'b110,
        ST_RESP   = 3'b111
    } ddf_st_e;

    ddf_cyc_if cyc ();

    ddf_st_e     state;
    ddf_op_e     curOp;
    logic [26:0] curAddr;
    logic [15:0] curData;
    logic [2:0]  stepIdx;
    logic [7:0]  waitCnt;
    logic        refuse;
    ddf_step_s   step;
    logic [26:0] dieBase;
    logic [2:0]  lastStep;

    // ====================================================================
    // Command step table
    always_comb begin
        dieBase = curAddr[DIE_BIT] ? DIE1_BASE : DIE0_BASE;
        step    = '{addr: dieBase | UNLOCK1_ADDR, data: UNLOCK1_DATA};
        unique case (stepIdx)
            3'h0: step = '{addr: dieBase | UNLOCK1_ADDR, data: UNLOCK1_DATA};
            3'h1: step = '{addr: dieBase | UNLOCK2_ADDR, data: UNLOCK2_DATA};
            3'h2: step = '{addr: dieBase | UNLOCK1_ADDR,
                           data: (curOp == OP_ERASE) ? ERASE_SETUP : PROGRAM_CMD};
            3'h3: step = (curOp == OP_ERASE) ?
                         '{addr: dieBase | UNLOCK1_ADDR, data: UNLOCK1_DATA} :
                         '{addr: curAddr, data: curData};
            3'h4: step = '{addr: dieBase | UNLOCK2_ADDR, data: UNLOCK2_DATA};
            3'h5: step = '{addr: curAddr & SECTOR_MASK, data: SECTOR_ERASE};
            default: step = '{addr: dieBase | UNLOCK1_ADDR, data: UNLOCK1_DATA};
        endcase
        lastStep = (curOp == OP_ERASE) ? ERASE_STEPS - 3'h1 : PROG_STEPS - 3'h1;
        // Outermost sector of either die: index 0 or last within the die
        refuse = protectOuter && (cmdOp == OP_ERASE || cmdOp == OP_PROGRAM) &&
                 (cmdAddr[25:16] == 10'h000 || cmdAddr[25:16] == LAST_DIE_SECTOR);
    end

    assign cmdReady          = (state == ST_IDLE);
    assign cyc.addr          = (state == ST_READ) ? curAddr : step.addr;
    assign cyc.wdata         = step.data;
    assign cyc.wr            = (state == ST_WRITE);
    assign reservedTestInput = 1'b0;

    // ====================================================================
    // Main sequencer
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            state   <= ST_RSTLOW;
            waitCnt <= RESET_CYC;
            stepIdx <= 3'h0;
            cyc.req <= 1'b0;
        end else begin
            unique case (state)
                ST_RSTLOW: begin
                    if (waitCnt == 8'h01) begin
                        state   <= ST_RSTREC;
                        waitCnt <= RESREC_CYC;
                    end else begin
                        waitCnt <= waitCnt - 8'h01;
                    end
                end
                ST_RSTREC: begin
                    if (waitCnt == 8'h01) begin
                        state <= ST_RESP;
                    end else begin
                        waitCnt <= waitCnt - 8'h01;
                    end
                end
                ST_IDLE: begin
                    stepIdx <= 3'h0;
                    if (cmdValid) begin
                        if (refuse) begin
                            state <= ST_RESP;
                        end else begin
                            unique case (ddf_op_e'(cmdOp))
                                OP_READ:    state <= ST_READ;
                                OP_PROGRAM: state <= ST_WRITE;
                                OP_ERASE:   state <= ST_WRITE;
                                OP_RESET:   state <= ST_RSTLOW;
                            endcase
                            cyc.req <= (cmdOp != OP_RESET);
                            waitCnt <= RESET_CYC;
                        end
                    end
                end
                ST_WRITE: begin
                    if (cyc.done) begin
                        if (stepIdx == lastStep) begin
                            cyc.req <= 1'b0;
                            state   <= ST_SETTLE;
                            waitCnt <= SETTLE_CYC;
                        end else begin
                            stepIdx <= stepIdx + 3'h1;
                        end
                    end
                end
                ST_READ: begin
                    if (cyc.done) begin
                        cyc.req <= 1'b0;
                        state   <= ST_RESP;
                    end
                end
                ST_SETTLE: begin
                    if (waitCnt == 8'h01) begin
                        state <= ST_BUSY;
                    end else begin
                        waitCnt <= waitCnt - 8'h01;
                    end
                end
                ST_BUSY: begin
                    if (readyBusyN) begin
                        state <= ST_RESP;
                    end
                end
                ST_RESP: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // ====================================================================
    // Command capture and answer
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            curOp    <= OP_READ;
            curAddr  <= 27'h0000000;
            curData  <= 16'h0000;
            rspValid <= 1'b0;
            rspError <= 1'b0;
            rspData  <= 16'h0000;
        end else begin
            if (state == ST_IDLE && cmdValid) begin
                curOp    <= ddf_op_e'(cmdOp);
                curAddr  <= cmdAddr;
                curData  <= cmdData;
                rspError <= refuse;
            end
            rspValid <= (state == ST_RESP);
            if (state == ST_READ && cyc.done) begin
                rspData <= cyc.rdata;
            end
        end
    end

    // ====================================================================
    // Reset, write protect and acceleration pins
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            flashResetN    <= 1'b0;
            flashWpN       <= 1'b1;
            flashWpElevate <= 1'b0;
        end else begin
            flashResetN    <= !(state == ST_RSTLOW);
            flashWpN       <= !protectOuter;
            flashWpElevate <= accelEnable && !protectOuter;
        end
    end

    ddf_bus_cycle u_bus_cycle (
        .mclk       (mclk),
        .nrst       (nrst),
        .cyc        (cyc.slave),
        .flashAddr  (flashAddr),
        .flashDqIn  (flashDqIn),
        .flashDqOut (flashDqOut),
        .flashDqOe  (flashDqOe),
        .flashCeN   (flashCeN),
        .flashOeN   (flashOeN),
        .flashWeN   (flashWeN)
    );

    // ====================================================================
    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    a_unlock_die: assert property ((state == ST_WRITE && stepIdx < 3'h2) |->
        (cyc.addr[DIE_BIT] == curAddr[DIE_BIT] && cyc.addr[25:0] ==
         (stepIdx == 3'h0 ? UNLOCK1_ADDR[25:0] : UNLOCK2_ADDR[25:0])))
        else $error("unlock cycle sent to wrong die");
    a_die_base: assert property ((state == ST_WRITE) |->
        (cyc.addr[DIE_BIT] == curAddr[DIE_BIT]))
        else $error("command address lost die base");
    a_sector_align: assert property ((state == ST_WRITE && curOp == OP_ERASE
        && stepIdx == 3'h5) |-> (cyc.addr[15:0] == 16'h0000 && cyc.wdata == 16'h0030))
        else $error("erase confirm not at sector start");
    a_erase_order: assert property ((state == ST_WRITE && curOp == OP_ERASE
        && stepIdx == 3'h2) |-> (cyc.wdata == 16'h0080 && cyc.addr[10:0] == 11'h555))
        else $error("erase setup cycle wrong");
    a_read_linear: assert property ((state == ST_READ && !flashOeN) |->
        (flashAddr == curAddr))
        else $error("array read address altered");
    a_busy_hold: assert property ((state == ST_BUSY && !readyBusyN) |=>
        (state == ST_BUSY))
        else $error("left busy wait while line low");
    a_busy_wait: assert property ((state == ST_WRITE && cyc.done && stepIdx == lastStep)
        |=> (state == ST_SETTLE)[*8])
        else $error("ready line sampled too early");
    a_reset_hold: assert property ($fell(flashResetN) |-> (!flashResetN)[*8])
        else $error("flash reset pulse too short");
    a_wp_refuse: assert property ((state == ST_IDLE && cmdValid && refuse) |=>
        (state == ST_RESP && rspError) ##1 rspValid)
        else $error("protected sector command not refused");
    a_wp_elevate: assert property (flashWpElevate |-> flashWpN)
        else $error("elevated level while protecting");
    a_reserved_low: assert property (!reservedTestInput)
        else $error("reserved input driven high");

    c_erase: cover property (state == ST_BUSY && curOp == OP_ERASE ##[1:1000] rspValid);
    c_program: cover property (state == ST_SETTLE && curOp == OP_PROGRAM);
    c_read_die1: cover property (state == ST_READ && curAddr[DIE_BIT] && cyc.done);
    c_refused: cover property (rspValid && rspError);
endmodule // ddf_host

/* File: tb/ddf_flash_model.sv */
`timescale 1ns/100ps
module ddf_flash_model
    import ddf_pkg::*;
(
    input  wire logic        tick,
    input  wire logic        slow,
    input  wire logic [26:0] flashAddr,
    input  wire logic [15:0] flashDqOut,
    input  wire logic        flashDqOe,
    input  wire logic        flashCeN,
    input  wire logic        flashOeN,
    input  wire logic        flashWeN,
    input  wire logic        flashResetN,
    input  wire logic        flashWpN,
    input  wire logic        flashWpElevate,
    input  wire logic        reservedTestInput,
    output logic [15:0]      flashDqIn,
    output logic             readyBusyN
);
    logic [15:0] mem[int];
    int          step[2];
    int          busy[2];
    int          ks[$];
    logic        weP = 1'b1;

    initial flashDqIn = 16'h0000;

    function automatic logic [15:0] peek(input int k);
        return mem.exists(k) ? mem[k] : 16'hFFFF;
    endfunction

    // ====================================================================
    // Command decode, one sequencer per die
    task automatic take(input int d, input logic [25:0] a, input logic [15:0] v);
        int s;
        int k;
        bit outer;
        s = step[d];
        k = d * 27'h4000000 + a;
        outer = !flashWpN && (a[25:16] == 10'h000 || a[25:16] == LAST_DIE_SECTOR);
        step[d] = 0;
        if (busy[d] != 0) return;
        if ((s == 0 || s == 3) && a == 26'h555 && v == UNLOCK1_DATA) step[d] = s + 1;
        if ((s == 1 || s == 4) && a == 26'h2AA && v == UNLOCK2_DATA) step[d] = s + 1;
        if (s == 2 && a == 26'h555 && v == ERASE_SETUP) step[d] = 3;
        if (s == 2 && a == 26'h555 && v == PROGRAM_CMD) step[d] = 9;
        if (s == 5 && v == SECTOR_ERASE && !outer) begin
            ks.delete();
            foreach (mem[j]) begin
                if ((j >> 16) == (k >> 16)) ks.push_back(j);
            end
            foreach (ks[i]) mem.delete(ks[i]);
            busy[d] = slow ? 300 : 40;
        end
        if (s == 9 && !outer) begin
            mem[k] = peek(k) & v;
            busy[d] = slow ? 300 : (flashWpElevate ? 4 : 20);
        end
    endtask

    // ====================================================================
    // Write capture, busy timing and read drive
    always @(posedge tick) begin
        weP <= flashWeN;
        for (int d = 0; d < 2; d++) begin
            if (busy[d] > 0) busy[d] = busy[d] - 1;
        end
        if (!flashResetN) begin
            step = '{0, 0};
            busy = '{0, 0};
        end else if (flashWeN && !weP && !flashCeN && flashDqOe
                     && reservedTestInput === 1'b0) begin
            take(int'(flashAddr[26]), flashAddr[25:0], flashDqOut);
        end
        if (!flashCeN && !flashOeN && !flashDqOe) begin
            flashDqIn <= peek(int'(flashAddr));
        end else begin
            flashDqIn <= ~flashDqIn;
        end
    end

    assign readyBusyN = (busy[0] == 0 && busy[1] == 0);
endmodule // ddf_flash_model

/* File: tb/dual_die_flash_command_routing_bench.sv */
`timescale 1ns/100ps
module dual_die_flash_command_routing_bench
    import ddf_pkg::*;
;
    logic        mclk, nrst, cmdValid, cmdReady, rspValid, rspError, protectOuter;
    logic        accelEnable, slow, flashDqOe, flashCeN, flashOeN, flashWeN, flashResetN;
    logic        flashWpN, flashWpElevate, reservedTestInput, readyBusyN;
    logic        sawBusy, sawRst, rtHigh, e;
    logic [1:0]  cmdOp;
    logic [26:0] cmdAddr, flashAddr, a;
    logic [15:0] cmdData, rspData, flashDqIn, flashDqOut, q;
    int          errors, compares, ceLow;
    logic [15:0] expMem[int];

    ddf_host i_ddf_host (.mclk, .nrst, .cmdValid, .cmdReady, .cmdOp, .cmdAddr, .cmdData,
        .rspValid, .rspError, .rspData, .protectOuter, .accelEnable, .flashAddr, .flashDqIn,
        .flashDqOut, .flashDqOe, .flashCeN, .flashOeN, .flashWeN, .flashResetN, .flashWpN,
        .flashWpElevate, .reservedTestInput, .readyBusyN);

    ddf_flash_model i_ddf_flash_model (.tick(mclk), .slow, .flashAddr, .flashDqOut, .flashDqOe,
        .flashCeN,
        .flashOeN, .flashWeN, .flashResetN, .flashWpN, .flashWpElevate, .reservedTestInput,
        .flashDqIn, .readyBusyN);

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        if (flashCeN === 1'b0) ceLow++;
        if (readyBusyN === 1'b0) sawBusy <= 1'b1;
        if (flashResetN === 1'b0) sawRst <= 1'b1;
        if (reservedTestInput !== 1'b0) rtHigh <= 1'b1;
    end

    // ====================================================================
    // Comparison and closing
    task automatic chkData(input string what, input logic [15:0] ex, input logic [15:0] g);
        compares++;
        if (g !== ex) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, ex, g);
        end
    endtask

    task automatic chkFlag(input string what, input logic ex, input logic g);
        compares++;
        if (g !== ex) begin
            errors++;
            $display("mismatch %s expected %b seen %b", what, ex, g);
        end
    endtask

    task automatic complete_run;
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    function automatic logic [15:0] expOf(input logic [26:0] ad);
        return expMem.exists(int'(ad)) ? expMem[int'(ad)] : 16'hFFFF;
    endfunction

    function automatic bit outer(input logic [26:0] ad);
        return protectOuter && (ad[25:16] == 10'h000 || ad[25:16] == LAST_DIE_SECTOR);
    endfunction

    // ====================================================================
    // Command driver, entered just after a clock edge
    task automatic run(input logic [1:0] op, input logic [26:0] ad, input logic [15:0] d);
        int n;
        cmdOp = op;
        cmdAddr = ad;
        cmdData = d;
        cmdValid = 1'b1;
        for (n = 0; n < 20000 && cmdReady !== 1'b1; n++) begin
            @(posedge mclk);
            #1;
        end
        @(posedge mclk);
        #1 cmdValid = 1'b0;
        for (n = 0; n < 20000 && rspValid !== 1'b1; n++) begin
            @(posedge mclk);
            #1;
        end
        if (n == 20000) errors++;
        e = rspError;
        q = rspData;
        chkFlag("ready at done", 1'b1, readyBusyN);
    endtask

    task automatic rd(input logic [26:0] ad);
        run(OP_READ, ad, 16'h0000);
        chkData("read data", expOf(ad), q);
    endtask

    task automatic prog(input logic [26:0] ad, input logic [15:0] d);
        int c0;
        bit p;
        p = outer(ad);
        c0 = ceLow;
        run(OP_PROGRAM, ad, d);
        chkFlag("program refused", p, e);
        if (p) chkFlag("program pins idle", 1'b1, ceLow == c0);
        else expMem[int'(ad)] = expOf(ad) & d;
        rd(ad);
    endtask

    task automatic ers(input logic [26:0] ad);
        int c0;
        int ks[$];
        bit p;
        p = outer(ad);
        c0 = ceLow;
        run(OP_ERASE, ad, 16'h0000);
        chkFlag("erase refused", p, e);
        if (p) chkFlag("erase pins idle", 1'b1, ceLow == c0);
        foreach (expMem[k]) begin
            if (!p && (k >> 16) == int'(ad[26:16])) ks.push_back(k);
        end
        foreach (ks[i]) expMem.delete(ks[i]);
        rd(ad & SECTOR_MASK);
        rd(ad | 27'h000FFFF);
    endtask

    initial begin
        #(CLK_PERIOD_NS * 80000);
        errors++;
        complete_run;
    end

    // ====================================================================
    // Main sequence
    initial begin
        {nrst, cmdValid, protectOuter, accelEnable, slow} = 5'h00;
        {sawBusy, sawRst, rtHigh} = 3'h0;
        cmdOp = OP_READ;
        cmdAddr = 27'h0000000;
        cmdData = 16'h0000;
        errors = 0;
        compares = 0;
        ceLow = 0;
        void'($urandom(31));
        repeat (5) @(posedge mclk);
        #1 nrst = 1'b1;
        rd(27'h0000000);
        rd(27'h3FFFFFF);
        rd(27'h4000000);
        rd(27'h7FFFFFF);
        for (int i = 0; i < 6; i++) begin
            a = 27'($urandom);
            a[26] = i[0];
            prog(a, 16'($urandom));
        end
        sawBusy = 1'b0;
        slow = 1'b1;
        prog(27'h4012345, 16'h5A5A);
        chkFlag("busy seen", 1'b1, sawBusy);
        slow = 1'b0;
        prog(27'h005FFFF, 16'h0F0F);
        prog(27'h405FFFF, 16'h1234);
        prog(27'h4060000, 16'h4321);
        ers(27'h405ABCD);
        rd(27'h4060000);
        rd(27'h005FFFF);
        protectOuter = 1'b1;
        accelEnable = 1'b1;
        repeat (3) @(posedge mclk);
        #1 chkFlag("protect pin", 1'b0, flashWpN);
        chkFlag("no elevate while protected", 1'b0, flashWpElevate);
        prog(27'h0000010, 16'h0000);
        prog(27'h7FF0010, 16'h0000);
        ers(27'h4000000);
        ers(27'h3FF0000);
        prog(27'h0010010, 16'h00C3);
        protectOuter = 1'b0;
        repeat (3) @(posedge mclk);
        #1 chkFlag("protect released", 1'b1, flashWpN);
        chkFlag("elevate request", 1'b1, flashWpElevate);
        prog(27'h4100000, 16'h00FF);
        prog(27'h0000010, 16'hFF00);
        accelEnable = 1'b0;
        sawRst = 1'b0;
        run(OP_RESET, 27'h0000000, 16'h0000);
        chkFlag("reset pulse", 1'b1, sawRst);
        chkFlag("reset status", 1'b0, e);
        rd(27'h4012345);
        chkFlag("reserved input low", 1'b0, rtHigh);
        complete_run;
    end
endmodule // dual_die_flash_command_routing_bench
